// *** rtl/msp_consts.svh ***
// constants of the metering serial port: command fields, mode bit positions, sizes
// assumes inclusion by the port package and the port design file only
`ifndef MSP_CONSTS_SVH
`define MSP_CONSTS_SVH

// record and latch sizes
`define MSP_REC_BITS 32
`define MSP_NUM_RECS 8
`define MSP_CFG_BITS 6'h38
`define MSP_MODE_BITS 8

// command byte
`define MSP_CMD_BITS 8
`define MSP_SWAP_CMD 8'hFF
`define MSP_MODE_SPACE 3'h7
`define MSP_SSC_ADDR 6'h37

// mode bit positions inside the mode record
`define MSP_MB_OSC_RC 3'h0
`define MSP_MB_BOOST 3'h1
`define MSP_MB_CUR_CH2 3'h4
`define MSP_MB_CFG_SHADOW 3'h5
`define MSP_MB_PERMANENT 3'h6

// command buffer depth and mode record reset value
`define MSP_FIFO_DEPTH 16
`define MSP_MODE_RESET 8'h00

`endif

// *** rtl/msp_pkg.sv ***
// types shared by the metering serial port design
// assumes msp_consts.svh sits beside it
`include "msp_consts.svh"

package msp_pkg;

  typedef enum logic [1:0] {
    MSP_IDLE,
    MSP_WRITE,
    MSP_READ
  } msp_port_state_t;

  // one serial command byte, first bit in the top position
  typedef struct packed {
    logic value;
    logic [5:0] addr;
    logic command_execute_bit;
  } msp_cmd_t;

  typedef struct packed {
    logic [5:0] addr;
    logic value;
    logic permanent;
  } msp_cfg_wr_t;

endpackage : msp_pkg

// *** rtl/msp_serial_port.sv ***
// four-wire serial host port with mode signal set and command buffer
// assumes serial pins arrive already synchronous to ref_clk and far slower than it;
// rst_n is the power-on reset; pad pull-ups make undriven pins read high
//
// What this block does
// - holds eight mode signals in one record, five functional, three test
// - mode signals cleared by power-on reset and by system-signal-clear, kept over remote reset
// - system-signal-clear set: clears all system signals when chip select idles
// - command 0111000x clears, 1111000x sets the oscillator source select
// - boost bit clear: drivers normal; set: charge-pump drive signals
// - current channel bit picks channel 1 or 2 while tamper is disabled
// - config source bit routes 56 config bits from antifuse or shadow latches
// - permanent write bit clear: shadow only; set: shadow and antifuse
// - config source bit set disconnects antifuse sense amplifiers
// - command FF swaps record order to 5..8,1..4, not retained
// - while system-signal-clear is set only the swap command is accepted
// - thirty-two transmission latches; internals never reached from pins directly
// - chip select, strobe and clock all high: idle, no transfer
// - chip select low enables serial use of strobe, clock and data
// - with chip select low, strobe high reads, strobe low writes
// - chip select high with strobe high copies results into transmission latches
// - data pin drives when reading, input when writing or idle
// - undriven serial pins read high, high is the inactive level
// - data changes on trailing clock edge, sampled on the leading edge
// - first data bit begins with first clock activation after chip select
// - command byte: value, six-bit address, then a latching don't-care bit
// - write latching comes from the last clock pulse of the command
// - reads take 32 clocks per record, up to eight records in order

`include "msp_consts.svh"

module msp_fifo #(
  parameter int WIDTH = `MSP_CMD_BITS,
  parameter int DEPTH = `MSP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : msp_fifo

module msp_serial_port #(
  parameter int FIFO_DEPTH = `MSP_FIFO_DEPTH
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic serial_chip_select_n,
  input wire logic direction_latch_strobe,
  input wire logic serial_bit_clock,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  // result records from the metering core
  input wire logic [`MSP_REC_BITS-1:0] record_word,
  output logic [2:0] record_sel,
  output logic latch_results,
  // configuration latch writes
  output logic cfg_wr_valid,
  output msp_pkg::msp_cfg_wr_t cfg_wr,
  input wire logic cfg_ready,
  // mode signals and their effects
  input wire logic tamper_enabled,
  output logic [`MSP_MODE_BITS-1:0] mode_data_record,
  output logic osc_rc_select,
  output logic boost_drive_en,
  output logic current_ch2_sel,
  output logic cfg_from_shadow,
  output logic antifuse_sense_off,
  output logic system_clear_pulse,
  output logic cmd_fifo_ready
);
  msp_pkg::msp_port_state_t state_q;
  msp_pkg::msp_port_state_t state_d;
  logic cs_n_q;
  logic sclk_q;
  logic sclk_fall;
  logic sclk_rise;
  logic [6:0] wsh_q;
  logic [2:0] wcnt_q;
  logic [4:0] ridx_q;
  logic [2:0] rec_q;
  logic load_pend_q;
  logic load_go_q;
  logic [`MSP_REC_BITS-1:0] latch_q;
  logic swap_q;
  logic ssc_q;
  logic [`MSP_MODE_BITS-1:0] mode_q;
  logic push;
  logic push_ready;
  msp_pkg::msp_cmd_t push_cmd;
  logic pop_valid;
  logic pop;
  msp_pkg::msp_cmd_t pop_cmd;
  logic pop_swap;
  logic pop_taken;
  logic ssc_fire;

  // all serial pins are active low; leading clock edge is the fall
  assign sclk_fall = sclk_q && !serial_bit_clock;
  assign sclk_rise = !sclk_q && serial_bit_clock;

  // chip select low enables the port, strobe picks direction
  always_comb
  begin
    if (serial_chip_select_n)
    begin
      state_d = msp_pkg::MSP_IDLE;
    end
    else if (direction_latch_strobe)
    begin
      state_d = msp_pkg::MSP_READ;
    end
    else
    begin
      state_d = msp_pkg::MSP_WRITE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= msp_pkg::MSP_IDLE;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cs_n_q <= serial_chip_select_n;
      sclk_q <= serial_bit_clock;
    end
  end

  // the eighth leading edge completes the command
  assign push = (state_q == msp_pkg::MSP_WRITE) && (state_d == msp_pkg::MSP_WRITE) && sclk_fall && (wcnt_q == 3'h7);
  assign push_cmd = {wsh_q, serial_data_line_i};

  // write data sampled on the leading edge
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wsh_q <= '0;
      wcnt_q <= '0;
    end
    // leaving write mode drops a partial byte
    else if (state_q != msp_pkg::MSP_WRITE || state_d != msp_pkg::MSP_WRITE)
    begin
      wcnt_q <= '0;
    end
    else if (sclk_fall)
    begin
      wsh_q <= {wsh_q[5:0], serial_data_line_i};
      wcnt_q <= wcnt_q + 3'h1;
    end
  end

  // commands are decoded on the core side so config stalls lose serial bytes only once the buffer is full
  msp_fifo #(
    .WIDTH(`MSP_CMD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_cmd),
    .out_valid(pop_valid),
    .out_ready(pop_taken),
    .out_data(pop_cmd)
  );

  assign pop_taken = !cfg_wr_valid || cfg_ready;
  assign pop = pop_valid && pop_taken;
  assign pop_swap = (pop_cmd == `MSP_SWAP_CMD);
  // clear waits for idle and a drained buffer
  assign ssc_fire = ssc_q && (state_q == msp_pkg::MSP_IDLE) && !pop_valid;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cmd_fifo_ready <= 1'b1;
    end
    else
    begin
      cmd_fifo_ready <= push_ready;
    end
  end

  // mode record written by address, cleared by power-on reset and by system clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode_q <= `MSP_MODE_RESET;
    end
    else if (ssc_fire)
    begin
      mode_q <= `MSP_MODE_RESET;
    end
    else if (pop && !pop_swap && !ssc_q && pop_cmd.addr[5:3] == `MSP_MODE_SPACE)
    begin
      mode_q[pop_cmd.addr[2:0]] <= pop_cmd.value;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ssc_q <= 1'b0;
      system_clear_pulse <= 1'b0;
    end
    else
    begin
      system_clear_pulse <= ssc_fire;
      if (ssc_fire)
      begin
        ssc_q <= 1'b0;
      end
      else if (pop && !ssc_q && pop_cmd.addr == `MSP_SSC_ADDR && pop_cmd.value)
      begin
        ssc_q <= 1'b1;
      end
    end
  end

  // config writes carry the permanent flag of the moment
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cfg_wr_valid <= 1'b0;
      cfg_wr <= '0;
    end
    else if (pop && !pop_swap && !ssc_q && pop_cmd.addr < `MSP_CFG_BITS)
    begin
      cfg_wr_valid <= 1'b1;
      cfg_wr <= {pop_cmd.addr, pop_cmd.value, mode_q[`MSP_MB_PERMANENT]};
    end
    else if (cfg_ready)
    begin
      cfg_wr_valid <= 1'b0;
    end
  end

  // swap holds only until the port next returns idle after a read
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      swap_q <= 1'b0;
    end
    else if (pop && pop_swap)
    begin
      swap_q <= 1'b1;
    end
    else if (state_q == msp_pkg::MSP_READ && state_d == msp_pkg::MSP_IDLE)
    begin
      swap_q <= 1'b0;
    end
  end

  // read position: 32 bits per record, records in order
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ridx_q <= '0;
      rec_q <= '0;
      load_pend_q <= 1'b0;
    end
    else if (state_q != msp_pkg::MSP_READ || state_d != msp_pkg::MSP_READ)
    begin
      ridx_q <= '0;
      rec_q <= '0;
      load_pend_q <= (state_d == msp_pkg::MSP_READ);
    end
    // next bit presented on the trailing edge
    else if (sclk_rise)
    begin
      ridx_q <= ridx_q + 5'h01;
      load_pend_q <= (ridx_q == 5'h1F);
      if (ridx_q == 5'h1F)
      begin
        rec_q <= rec_q + 3'h1;
      end
    end
    else
    begin
      load_pend_q <= 1'b0;
    end
  end

  // swapped order flips the top bit of the record number
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      record_sel <= '0;
      latch_results <= 1'b0;
      load_go_q <= 1'b0;
    end
    else
    begin
      record_sel <= {rec_q[2] ^ swap_q, rec_q[1:0]};
      // load one cycle late so the core already answers the new record_sel
      load_go_q <= load_pend_q;
      // copy while chip select and strobe are high
      latch_results <= serial_chip_select_n && direction_latch_strobe;
    end
  end

  // transmission latches stand between pins and internal records
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      latch_q <= '0;
    end
    else if (latch_results || load_go_q)
    begin
      latch_q <= record_word;
    end
  end

  // drive only in read mode; bytes low first, bits high first
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      serial_data_line_o <= 1'b1;
      serial_data_line_oe <= 1'b0;
    end
    else
    begin
      serial_data_line_o <= (state_q == msp_pkg::MSP_READ) ? latch_q[{ridx_q[4:3], ~ridx_q[2:0]}] : 1'b1;
      serial_data_line_oe <= (state_q == msp_pkg::MSP_READ) && (state_d == msp_pkg::MSP_READ);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode_data_record <= `MSP_MODE_RESET;
      osc_rc_select <= 1'b0;
      boost_drive_en <= 1'b0;
      current_ch2_sel <= 1'b0;
      cfg_from_shadow <= 1'b0;
      antifuse_sense_off <= 1'b0;
    end
    else
    begin
      mode_data_record <= mode_q;
      osc_rc_select <= mode_q[`MSP_MB_OSC_RC];
      boost_drive_en <= mode_q[`MSP_MB_BOOST];
      current_ch2_sel <= mode_q[`MSP_MB_CUR_CH2] && !tamper_enabled;
      cfg_from_shadow <= mode_q[`MSP_MB_CFG_SHADOW];
      antifuse_sense_off <= mode_q[`MSP_MB_CFG_SHADOW];
    end
  end

  property p_oe_read;
    @(posedge ref_clk) disable iff (!rst_n)
    serial_data_line_oe |-> $past(state_q) == msp_pkg::MSP_READ && !$past(serial_chip_select_n);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("data driven outside read");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    serial_chip_select_n ##1 serial_chip_select_n |=> !serial_data_line_oe && !push;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("transfer while idle");

  property p_partial_drop;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(serial_chip_select_n) |=> wcnt_q == 3'h0 ##1 wcnt_q == 3'h0;
  endproperty
  a_partial_drop: assert property (p_partial_drop) else $error("partial byte kept");

  property p_ssc_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    ssc_fire |=> mode_q == `MSP_MODE_RESET && !ssc_q ##1 system_clear_pulse == 1'b0 && mode_data_record == '0;
  endproperty
  a_ssc_clear: assert property (p_ssc_clear) else $error("system clear incomplete");

  property p_ssc_ignore;
    @(posedge ref_clk) disable iff (!rst_n)
    pop && ssc_q && !pop_swap |=> $stable(mode_q) && !$rose(cfg_wr_valid);
  endproperty
  a_ssc_ignore: assert property (p_ssc_ignore) else $error("command taken during clear");

  property p_mode_write;
    @(posedge ref_clk) disable iff (!rst_n)
    pop && !pop_swap && !ssc_q && !ssc_fire && pop_cmd.addr[5:3] == `MSP_MODE_SPACE
    |=> mode_q[$past(pop_cmd.addr[2:0])] == $past(pop_cmd.value) ##1 mode_data_record == $past(mode_q);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bit not written");

  property p_cfg_perm;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(cfg_wr_valid) |-> cfg_wr.permanent == $past(mode_q[`MSP_MB_PERMANENT]);
  endproperty
  a_cfg_perm: assert property (p_cfg_perm) else $error("permanent flag wrong");

  property p_swap_drop;
    @(posedge ref_clk) disable iff (!rst_n)
    state_q == msp_pkg::MSP_READ && serial_chip_select_n && !(pop && pop_swap) |=> !swap_q;
  endproperty
  a_swap_drop: assert property (p_swap_drop) else $error("swap retained");

  property p_latch_copy;
    @(posedge ref_clk) disable iff (!rst_n)
    serial_chip_select_n && direction_latch_strobe ##1 1'b1 |=> latch_q == $past(record_word);
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("results not latched");

  property p_read_start;
    @(posedge ref_clk) disable iff (!rst_n)
    state_q != msp_pkg::MSP_READ && state_d == msp_pkg::MSP_READ |=> ridx_q == 5'h00 && rec_q == 3'h0;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read not from bit zero");
endmodule : msp_serial_port

// *** verification/msp_host_model.sv ***
// host side model of the four-wire serial link: chip select, strobe, clock, data
// assumes ref_clk runs the bench; the data line is resolved outside with a pull-up
module msp_host_model (
  // clock
  input wire logic ref_clk,
  // serial pins towards the port
  output logic cs_n,
  output logic strobe,
  output logic sclk,
  output logic dat,
  output logic dat_en,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cs_n = 1'b1;
    strobe = 1'b1;
    sclk = 1'b1;
    dat = 1'b1;
    dat_en = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic go_idle();
    cs_n <= 1'b1;
    strobe <= 1'b1;
    sclk <= 1'b1;
    dat_en <= 1'b0;
    // released line goes back to the pull-up level
    dat <= 1'b1;
    tick(8);
  endtask : go_idle

  // strobe picks direction before chip select
  task automatic open_frame(input logic rd);
    strobe <= rd;
    tick(1);
    cs_n <= 1'b0;
    dat_en <= !rd;
    tick(6);
  endtask : open_frame

  // data set after rise, sampled at fall
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      dat <= b[7-i];
      tick(5);
      sclk <= 1'b0;
      tick(5);
      sclk <= 1'b1;
    end
    tick(1);
  endtask : send_bits

  // one bit per clock, sampled before the fall
  task automatic read_bits(input int n, output logic [39:0] v);
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(5);
      v = {v[38:0], line};
      sclk <= 1'b0;
      tick(5);
      sclk <= 1'b1;
    end
    tick(1);
  endtask : read_bits
endmodule : msp_host_model

// *** verification/msp_serial_port_bench.sv ***
// self-checking bench of the serial port: mode writes, config writes, reads, clears
// assumes msp_pkg and msp_serial_port compiled first; the core side is modelled here
module msp_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk;
  logic rst_n;
  logic cs_n, strobe, sclk, m_dat, m_en, line;
  logic d_o, d_oe;
  logic [31:0] record_word;
  logic [2:0] record_sel;
  logic latch_results, cfg_wr_valid, cfg_ready, tamper_enabled;
  msp_pkg::msp_cfg_wr_t cfg_wr;
  logic [7:0] mode_data_record;
  logic osc_rc_select, boost_drive_en, current_ch2_sel, cfg_from_shadow;
  logic antifuse_sense_off, system_clear_pulse, cmd_fifo_ready;
  int miscompares, compares, cycles, cfg_count, cfg_base;
  logic saw_clear = 1'b0;
  logic [39:0] rd;
  logic [7:0] exp_mode;
  logic [7:0] cmds [5] = '{8'hF0, 8'hF2, 8'hF8, 8'hFA, 8'hFC};

  always #5 ref_clk = ~ref_clk;

  // pull-up wins whenever nobody drives the line
  assign line = d_oe ? d_o : (m_en ? m_dat : 1'b1);
  // each byte of a record is distinct and carries the record number
  assign record_word = {2'h3, 3'h5, record_sel, 2'h2, 3'h5, record_sel,
                        2'h1, 3'h5, record_sel, 2'h0, 3'h5, record_sel};

  msp_host_model hm (
    .ref_clk(ref_clk),
    .cs_n(cs_n),
    .strobe(strobe),
    .sclk(sclk),
    .dat(m_dat),
    .dat_en(m_en),
    .line(line)
  );

  msp_serial_port #(
    .FIFO_DEPTH(16)
  ) dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .serial_chip_select_n(cs_n),
    .direction_latch_strobe(strobe),
    .serial_bit_clock(sclk),
    .serial_data_line_i(line),
    .serial_data_line_o(d_o),
    .serial_data_line_oe(d_oe),
    .record_word(record_word),
    .record_sel(record_sel),
    .latch_results(latch_results),
    .cfg_wr_valid(cfg_wr_valid),
    .cfg_wr(cfg_wr),
    .cfg_ready(cfg_ready),
    .tamper_enabled(tamper_enabled),
    .mode_data_record(mode_data_record),
    .osc_rc_select(osc_rc_select),
    .boost_drive_en(boost_drive_en),
    .current_ch2_sel(current_ch2_sel),
    .cfg_from_shadow(cfg_from_shadow),
    .antifuse_sense_off(antifuse_sense_off),
    .system_clear_pulse(system_clear_pulse),
    .cmd_fifo_ready(cmd_fifo_ready)
  );

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cfg_wr_valid === 1'b1 && cfg_ready === 1'b1)
      cfg_count++;
    if (system_clear_pulse === 1'b1)
      saw_clear = 1'b1;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic send_frame(input logic [7:0] b);
    hm.open_frame(1'b0);
    hm.send_bits(b, 8);
    hm.go_idle();
  endtask : send_frame

  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    cfg_ready = 1'b1;
    tamper_enabled = 1'b0;
    exp_mode = 8'h00;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    hm.tick(4);
    check(mode_data_record, 8'h00);
    check(d_oe, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      send_frame(cmds[k]);
      exp_mode[cmds[k][3:1]] = 1'b1;
      check(mode_data_record, exp_mode);
    end
    check({osc_rc_select, boost_drive_en, current_ch2_sel}, 3'h7);
    check({cfg_from_shadow, antifuse_sense_off}, 2'h3);
    tamper_enabled <= 1'b1;
    hm.tick(3);
    check(current_ch2_sel, 1'b0);
    tamper_enabled <= 1'b0;
    cfg_ready <= 1'b0;
    send_frame(8'h5F);
    check({cfg_wr_valid, cfg_wr}, {1'b1, 6'h2F, 1'b0, 1'b1});
    cfg_ready <= 1'b1;
    hm.tick(2);
    check(cfg_wr_valid, 1'b0);
    for (int k = 0; k < 5; k++)
      send_frame(cmds[k] & 8'h7F);
    check({osc_rc_select, boost_drive_en, current_ch2_sel, cfg_from_shadow}, 4'h0);
    check(mode_data_record, 8'h00);
    hm.open_frame(1'b0);
    hm.send_bits(8'hF2, 5);
    hm.go_idle();
    // a kept partial byte would make this frame complete a boost set
    send_frame(8'h70);
    check(boost_drive_en, 1'b0);
    // stall the core so commands pile up until the buffer refuses
    cfg_ready <= 1'b0;
    cfg_base = cfg_count;
    hm.open_frame(1'b0);
    for (int k = 0; k < 18; k++)
      hm.send_bits(8'h02, 8);
    hm.tick(4);
    check(cmd_fifo_ready, 1'b0);
    hm.go_idle();
    cfg_ready <= 1'b1;
    hm.tick(40);
    check(cmd_fifo_ready, 1'b1);
    check(cfg_count - cfg_base, 17);
    check(latch_results, 1'b1);
    hm.open_frame(1'b1);
    check(d_oe, 1'b1);
    hm.read_bits(40, rd);
    check(rd, {8'h28, 8'h68, 8'hA8, 8'hE8, 8'h29});
    hm.go_idle();
    check(d_oe, 1'b0);
    hm.open_frame(1'b0);
    hm.send_bits(8'hFF, 8);
    hm.open_frame(1'b1);
    hm.read_bits(8, rd);
    check(rd[7:0], 8'h2C);
    hm.go_idle();
    hm.open_frame(1'b1);
    hm.read_bits(8, rd);
    check(rd[7:0], 8'h28);
    hm.go_idle();
    hm.open_frame(1'b0);
    hm.send_bits(8'hF0, 8);
    hm.send_bits(8'hEF, 8);
    hm.send_bits(8'hF2, 8);
    hm.tick(6);
    check({osc_rc_select, boost_drive_en}, 2'h2);
    hm.go_idle();
    hm.tick(4);
    check({saw_clear, mode_data_record}, {1'b1, 8'h00});
    send_frame(8'hF2);
    check(boost_drive_en, 1'b1);
    rst_n <= 1'b0;
    hm.tick(2);
    rst_n <= 1'b1;
    hm.tick(3);
    check({boost_drive_en, mode_data_record}, 9'h000);
    tally_and_finish();
  end
endmodule : msp_serial_port_bench
